// ==== rtl/spi_pkg.sv ====
package spi_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_TX = 8'h00;
	localparam logic [7:0] ADDR_RX = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CFG = 8'h0c;
	// ==========================================
	// control_status_reg fields
	localparam int CR_ENABLE = 0;
	localparam int CR_CPOL = 1;
	localparam int CR_CPHA = 2;
	localparam int CR_RXFULL = 3;
	localparam int CR_TXEMPTY = 4;
	localparam int CR_DONE = 5;
	localparam int CR_OVERRUN = 6;
	localparam int CR_LSBFIRST = 7;
	// ==========================================
	// configuration fields
	localparam int CFG_SLAVE = 0;
	localparam int CFG_INTSEL = 1;
	localparam int CFG_SELEN_N = 2;
	localparam int CFG_SEL_N = 3;
	localparam int CFG_CLKSEL_LO = 5;
	localparam logic [7:0] CR_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int BIT_COUNT = 8;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_TRAIL = 2'b11
	} phase_t;
endpackage

// ==== rtl/clk_div_if.sv ====
`timescale 1ns/1ps
interface clk_div_if;
	logic run;
	logic [2:0] sel;
	logic tick;
	modport owner (output run, output sel, input tick);
	modport divider (input run, input sel, output tick);
endinterface

// ==== rtl/spi_clk_div.sv ====
`timescale 1ns/1ps
module spi_clk_div
	import spi_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control
	clk_div_if.divider div
);
	// ==========================================
	// eight stage divider, tap resynchronised
	logic [7:0] stage;
	logic tapSync;
	logic tapLast;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			stage <= 8'h00;
		else if (!div.run)
			stage <= 8'h00;
		else
			stage <= stage + 8'h01;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			tapSync <= 1'b0;
			tapLast <= 1'b0;
		end
		else if (!div.run)
		begin
			tapSync <= 1'b0;
			tapLast <= 1'b0;
		end
		else
		begin
			tapSync <= stage[div.sel];
			tapLast <= tapSync;
		end
	// one tick per half bit period: /2 gives a tick each cycle
	assign div.tick = div.run && (tapSync != tapLast);
endmodule

// ==== rtl/spi_block.sv ====
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// - phase 0: sample leading, shift trailing
// - phase 1: shift leading, sample trailing
// - clock idles at polarity level
// - master drives MSb/LSb, clock idles
// - ripple divider /2../256, resynchronised
// - disabled holds reset; enable releases synchronously
// - master disable: idle pins, clear status
// - write starts transfer, empty reasserts, duplex
// - back to back byte if buffered
// - empty set on enable, cleared by write
// - empty interrupt armed after first load
// - rx full on eighth sample, read clears
// - complete after eighth clock finishes
// - overrun when rx full still set
// - slave output high when disabled
// - slave drives only enabled and selected
// - select from pin or firmware bit
// - deselect resets slave, output high
// - slave loads shifter under three conditions
// - phase 0: busy from select fall
// - phase 1: busy from leading edge
// - interrupt select picks empty or complete
// - control read clears complete
module spi_block
	import spi_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial pins
	output logic sclkOut,
	output logic sclkOe,
	input wire logic sclkIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic mosiIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic misoIn,
	input wire logic selPin_n,
	// interrupt request
	output logic irq
);
	// ==========================================
	// bus interface
	logic [7:0] ctrl;
	logic [7:0] cfg;
	logic [7:0] txBuf;
	logic [7:0] rxBuf;
	logic [7:0] shifter;
	logic wrPend;
	logic rdPend;
	logic [7:0] addrPend;
	logic accept;
	assign accept = hsel && hready && htrans[1];
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			wrPend <= 1'b0;
			rdPend <= 1'b0;
			addrPend <= 8'h00;
		end
		else
		begin
			wrPend <= accept && hwrite;
			rdPend <= accept && !hwrite;
			addrPend <= haddr;
		end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	logic wrTx, wrCtrl, wrCfg, rdRx, rdCtrl;
	assign wrTx = wrPend && addrPend == ADDR_TX;
	assign wrCtrl = wrPend && addrPend == ADDR_CTRL;
	assign wrCfg = wrPend && addrPend == ADDR_CFG;
	assign rdRx = rdPend && addrPend == ADDR_RX;
	assign rdCtrl = rdPend && addrPend == ADDR_CTRL;
	// read data registered at address phase
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			hrdata <= 32'h00000000;
		else if (accept && !hwrite)
			case (haddr)
				ADDR_RX: hrdata <= {24'h000000, rxBuf};
				ADDR_CTRL: hrdata <= {24'h000000, ctrl};
				ADDR_CFG: hrdata <= {24'h000000, cfg};
				default: hrdata <= 32'h00000000;
			endcase
	// ==========================================
	// configuration
	logic enabled, isSlave, cpol, cpha, lsbFirst;
	assign enabled = ctrl[CR_ENABLE];
	assign cpol = ctrl[CR_CPOL];
	assign cpha = ctrl[CR_CPHA];
	assign lsbFirst = ctrl[CR_LSBFIRST];
	assign isSlave = cfg[CFG_SLAVE];
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			cfg <= CFG_RESET;
		else if (wrCfg)
			cfg <= hwdata[7:0];
	logic selActive;
	assign selActive = cfg[CFG_SELEN_N] ? !selPin_n : !cfg[CFG_SEL_N];
	// ==========================================
	// status and sequencing
	logic txFull, armed, busy, shFull;
	logic [3:0] bitCnt;
	phase_t phase;
	logic sampleBit;
	logic setRx, setDone, setOvr, loadSh;
	function automatic logic outBit(input logic [7:0] v, input logic lsb);
		outBit = lsb ? v[0] : v[7];
	endfunction
	// master clocking
	clk_div_if divBus();
	assign divBus.run = enabled && !isSlave;
	assign divBus.sel = cfg[7:CFG_CLKSEL_LO];
	spi_clk_div u_div (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.div(divBus)
	);
	// slave edge detection on external clock and select
	logic sclkLast, selLast;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			sclkLast <= 1'b0;
			selLast <= 1'b0;
		end
		else
		begin
			sclkLast <= sclkIn;
			selLast <= selActive;
		end
	logic slvRun, lead, trail, selFall;
	assign slvRun = enabled && isSlave && selActive;
	assign lead = slvRun && (sclkIn != sclkLast) && (sclkIn != cpol);
	assign trail = slvRun && (sclkIn != sclkLast) && (sclkIn == cpol);
	assign selFall = enabled && isSlave && selActive && !selLast;
	// master edges from divider ticks
	logic mLead, mTrail, mStart;
	assign mStart = enabled && !isSlave && phase == ST_IDLE && txFull && divBus.tick;
	assign mLead = enabled && !isSlave && phase == ST_LEAD && divBus.tick;
	assign mTrail = enabled && !isSlave && phase == ST_TRAIL && divBus.tick;
	logic edgeLead, edgeTrail;
	assign edgeLead = isSlave ? lead : mLead;
	assign edgeTrail = isSlave ? trail : mTrail;
	logic sampleNow, lastEdge;
	assign sampleNow = cpha ? edgeTrail : edgeLead;
	assign lastEdge = edgeTrail && bitCnt == 4'(BIT_COUNT - 1);
	assign setRx = sampleNow && bitCnt == 4'(BIT_COUNT - 1);
	assign setDone = lastEdge;
	assign setOvr = setRx && ctrl[CR_RXFULL];
	// slave load: not busy, shifter empty, buffer full
	assign loadSh = isSlave ? (enabled && !busy && !shFull && txFull)
		: (mStart || (lastEdge && txFull));
	// master phase machine
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			phase <= ST_IDLE;
		else if (!enabled || isSlave)
			phase <= ST_IDLE;
		else
			case (phase)
				ST_IDLE: if (mStart) phase <= ST_LEAD;
				ST_LEAD: if (mLead) phase <= ST_TRAIL;
				ST_TRAIL:
					if (mTrail)
						phase <= (bitCnt == 4'(BIT_COUNT - 1)) && !txFull ? ST_IDLE : ST_LEAD;
				default: phase <= ST_IDLE;
			endcase
	// busy window
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			busy <= 1'b0;
		else if (!enabled || (isSlave && !selActive))
			busy <= 1'b0;
		else if (lastEdge)
			busy <= 1'b0;
		else if (isSlave && !cpha && (selFall || lead))
			busy <= 1'b1;
		else if (isSlave && cpha && lead)
			busy <= 1'b1;
		else if (!isSlave && mStart)
			busy <= 1'b1;
	// bit counter
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			bitCnt <= 4'h0;
		else if (!enabled || (isSlave && !selActive))
			bitCnt <= 4'h0;
		else if (edgeTrail)
			bitCnt <= (bitCnt == 4'(BIT_COUNT - 1)) ? 4'h0 : bitCnt + 4'h1;
	// shifter: full duplex
	logic inBit;
	assign inBit = isSlave ? mosiIn : misoIn;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			sampleBit <= 1'b0;
		else if (sampleNow)
			sampleBit <= inBit;
	logic shiftNow;
	assign shiftNow = cpha ? edgeLead && bitCnt != 4'h0 : edgeTrail;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			shifter <= DATA_RESET;
		else if (loadSh && !(isSlave && lastEdge))
			shifter <= txBuf;
		else if (edgeTrail && !cpha)
			shifter <= lsbFirst ? {sampleBit, shifter[7:1]} : {shifter[6:0], sampleBit};
		else if (shiftNow && cpha)
			shifter <= lsbFirst ? {sampleBit, shifter[7:1]} : {shifter[6:0], sampleBit};
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			shFull <= 1'b0;
		else if (!enabled || (isSlave && !selActive))
			shFull <= 1'b0;
		else if (loadSh)
			shFull <= 1'b1;
		else if (lastEdge)
			shFull <= 1'b0;
	// receive buffer latches the shifted byte
	logic [7:0] rxByte;
	assign rxByte = lsbFirst ? {inBit, shifter[7:1]} : {shifter[6:0], inBit};
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			rxBuf <= DATA_RESET;
		else if (setRx && cpha)
			rxBuf <= rxByte;
		else if (setRx && !cpha)
			rxBuf <= rxByte;
	// transmit buffer
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			txBuf <= DATA_RESET;
		else if (wrTx)
			txBuf <= hwdata[7:0];
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			txFull <= 1'b0;
		else if (!enabled)
			txFull <= 1'b0;
		else if (wrTx)
			txFull <= 1'b1;
		else if (loadSh)
			txFull <= 1'b0;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			armed <= 1'b0;
		else if (!enabled)
			armed <= 1'b0;
		else if (loadSh)
			armed <= 1'b1;
	// ==========================================
	// control and status register
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			ctrl <= CR_RESET;
		else
		begin
			if (wrCtrl)
			begin
				ctrl[CR_ENABLE] <= hwdata[CR_ENABLE];
				ctrl[CR_CPOL] <= hwdata[CR_CPOL];
				ctrl[CR_CPHA] <= hwdata[CR_CPHA];
				ctrl[CR_LSBFIRST] <= hwdata[CR_LSBFIRST];
			end
			ctrl[CR_TXEMPTY] <= enabled && !(txFull || wrTx) && !loadSh
				|| enabled && loadSh && !wrTx;
			if (!enabled)
			begin
				ctrl[CR_RXFULL] <= 1'b0;
				ctrl[CR_DONE] <= 1'b0;
				ctrl[CR_OVERRUN] <= 1'b0;
			end
			else
			begin
				if (setRx)
					ctrl[CR_RXFULL] <= 1'b1;
				else if (rdRx)
					ctrl[CR_RXFULL] <= 1'b0;
				if (setDone)
					ctrl[CR_DONE] <= 1'b1;
				else if (rdCtrl)
					ctrl[CR_DONE] <= 1'b0;
				if (setOvr)
					ctrl[CR_OVERRUN] <= 1'b1;
				else if (rdRx)
					ctrl[CR_OVERRUN] <= 1'b0;
			end
		end
	// ==========================================
	// pins and interrupt
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			sclkOut <= 1'b0;
		else if (!enabled || phase == ST_IDLE)
			sclkOut <= cpol;
		else if (mLead)
			sclkOut <= !cpol;
		else if (mTrail)
			sclkOut <= cpol;
	assign sclkOe = !isSlave;
	assign mosiOut = isSlave ? 1'b1 : outBit(shifter, lsbFirst);
	assign mosiOe = !isSlave;
	assign misoOut = slvRun ? outBit(shifter, lsbFirst) : 1'b1;
	assign misoOe = isSlave && slvRun;
	assign irq = cfg[CFG_INTSEL] ? ctrl[CR_DONE]
		: (ctrl[CR_TXEMPTY] && armed);
endmodule

// ==== tb/spi_block_monitor.sv ====
`timescale 1ns/1ps
// ==========
// port checks
module spi_block_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// bus
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// serial pins
	input wire logic sclkOut,
	input wire logic sclkOe,
	input wire logic mosiOe,
	input wire logic misoOut,
	input wire logic misoOe,
	input wire logic irq
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	logic rdTaken;
	assign rdTaken = hsel && hready && htrans[1] && !hwrite;
	property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
	property p_hold; !rdTaken |=> $stable(hrdata); endproperty
	property p_unmap; rdTaken && haddr >= 8'h10 |=> hrdata == 32'h0; endproperty
	property p_roles; misoOe |-> !sclkOe && !mosiOe; endproperty
	property p_rel; !misoOe |-> misoOut; endproperty
	property p_irq0; $rose(nrst) |-> !irq [*3]; endproperty
	property p_idle; $rose(nrst) |-> !sclkOut [*3]; endproperty
	property p_mpins; sclkOe |-> mosiOe; endproperty
	a_okay: assert property (p_okay)
		else $error("bus answer not okay");
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	a_roles: assert property (p_roles)
		else $error("slave drives master pins");
	a_rel: assert property (p_rel)
		else $error("released slave output not high");
	a_irq0: assert property (p_irq0)
		else $error("interrupt right after reset");
	a_idle: assert property (p_idle)
		else $error("clock not idle after reset");
	a_mpins: assert property (p_mpins)
		else $error("master clock without data");
	c_irq: cover property ($rose(irq));
	c_sclk: cover property ($rose(sclkOut));
	c_slave: cover property (misoOe);
endmodule
bind spi_block spi_block_monitor spi_block_monitor_inst (.*);

// ==== tb/spi_far_dev.sv ====
`timescale 1ns/1ps
// ==========
// far serial slave, msb first
module spi_far_dev (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic frm,
	input wire logic [7:0] txByte,
	output logic miso,
	output logic [7:0] rxByte
);
	logic [3:0] cnt;
	logic [3:0] idx;
	initial {miso, cnt, rxByte, idx} = '0;
	always @(sclk)
		if (frm)
		begin
			if ((sclk != cpol) ^ cpha)
				rxByte = {rxByte[6:0], mosi};
			cnt = cnt + 4'h1;
		end
	always @(negedge frm)
		cnt = 4'h0;
	// outside frames the line shows the inverse of its last level
	always @(cnt or frm)
	begin
		idx = (cnt - {3'h0, cpha}) >> 1;
		miso = frm ? txByte[3'd7 - idx[2:0]] : ~miso;
	end
endmodule

// ==== tb/spi_master_slave_timing_bench.sv ====
`timescale 1ns/1ps
module spi_master_slave_timing_bench
	import spi_pkg::*;
;
	logic clk_sys, nrst, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, misoIn;
	logic sclkIn, mosiIn, selPin_n, frm, cpol, cpha;
	logic [7:0] haddr, farTx, farRx;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	int error_cnt, n_tests, cyc;
	assign hready = hreadyout;
	spi_block spi_block_inst (.*);
	spi_far_dev spi_far_dev_inst (.sclk(sclkOut), .mosi(mosiOut), .cpol(cpol),
		.cpha(cpha), .frm(frm), .txByte(farTx), .miso(misoIn), .rxByte(farRx));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ==========
	// shared tasks
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		bus(0, ADDR_CTRL, 0);
		chk(rd, 32'(CR_RESET));
		bus(0, ADDR_CFG, 0);
		chk(rd, 32'(CFG_RESET));
		bus(1, 8'h14, 8'hff);
		bus(0, 8'h10, 0);
		chk(rd, 0);
		$display("reset values done");
	endtask
	task automatic t_master();
		logic [7:0] b;
		for (int m = 0; m < 4; m++)
		begin
			cpol = m[1];
			cpha = m[0];
			b = 8'h3c + 8'(m);
			farTx = 8'hc5 ^ b;
			frm <= 1'b0;
			bus(1, ADDR_CFG, 8'h02);
			bus(1, ADDR_CTRL, {5'h0, cpha, cpol, 1'b1});
			repeat (2) @(negedge clk_sys);
			chk(sclkOut, cpol);
			bus(0, ADDR_CTRL, 0);
			chk(rd, {27'h0, 2'b10, cpha, cpol, 1'b1});
			chk(irq, 0);
			frm <= 1'b1;
			bus(1, ADDR_TX, b);
			for (int i = 0; i < 3000 && irq !== 1'b1; i++)
				@(posedge clk_sys);
			frm <= 1'b0;
			bus(0, ADDR_CTRL, 0);
			chk(rd, {26'h0, 3'b111, cpha, cpol, 1'b1});
			@(posedge clk_sys);
			chk(irq, 0);
			chk(farRx, b);
			bus(1, ADDR_CTRL, 0);
			repeat (2) @(negedge clk_sys);
			chk(sclkOut, 0);
			bus(0, ADDR_CTRL, 0);
			chk(rd, 0);
			bus(0, ADDR_RX, 0);
			chk(rd, farTx);
		end
		$display("master modes done");
	endtask
	task automatic t_slave();
		bus(1, ADDR_CFG, 8'h09);
		bus(1, ADDR_CTRL, 8'h01);
		@(posedge clk_sys);
		chk(misoOut, 1);
		bus(1, ADDR_CFG, 8'h01);
		@(posedge clk_sys);
		chk(misoOe, 1);
		chk(sclkOe, 0);
		bus(1, ADDR_CTRL, 8'h00);
		@(posedge clk_sys);
		chk(misoOut, 1);
		$display("slave select done");
	endtask
	// ==========
	// main sequence and timeout
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			conclude();
		end
	end
	initial
	begin
		{nrst, hsel, hwrite, frm, cpol, cpha, sclkIn, mosiIn} = '0;
		{haddr, htrans, hwdata, farTx} = '0;
		selPin_n = 1'b1;
		hsize = 3'b010;
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_master();
		t_slave();
		conclude();
	end
endmodule
